// *** core/btx_pkg.sv ***
// constants, register map and command codes of the bit/transfer executor
// assumes a 32-bit classic Wishbone register window, byte addressed
package btx_pkg;

  localparam int BTX_ADR_W = 8;
  localparam int BTX_DAT_W = 32;
  localparam int BTX_MEM_AW = 16;
  localparam int BTX_IO_AW = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_IMM = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RF_IDX = 8'h0C;
  localparam logic [7:0] OFS_RF_DAT = 8'h10;
  localparam logic [7:0] OFS_SP = 8'h14;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PTR_LSB = 6;
  localparam int CMD_RD_LSB = 8;
  localparam int CMD_RR_LSB = 16;
  localparam int CMD_BIT_LSB = 24;

  // status_flags_word bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_ERR_BIT = 9;

  // pointer pair low-byte indices and the fixed code-read target
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [4:0] REG_R0 = 5'h00;

  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // execution lengths in core cycles
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // command codes
  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_ROTATE_RIGHT_CARRY = 6'h01;
  localparam logic [5:0] OP_ARITH_SHIFT_RIGHT = 6'h02;
  localparam logic [5:0] OP_STATUS_BIT_SET = 6'h03;
  localparam logic [5:0] OP_STATUS_BIT_CLEAR = 6'h04;
  localparam logic [5:0] OP_BIT_TO_TRANSFER_FLAG = 6'h05;
  localparam logic [5:0] OP_TRANSFER_FLAG_TO_BIT = 6'h06;
  localparam logic [5:0] OP_REG_COPY = 6'h07;
  localparam logic [5:0] OP_REG_PAIR_COPY = 6'h08;
  localparam logic [5:0] OP_IMMEDIATE_LOAD = 6'h09;
  localparam logic [5:0] OP_INDIRECT_LOAD = 6'h0A;
  localparam logic [5:0] OP_INDIRECT_LOAD_INC = 6'h0B;
  localparam logic [5:0] OP_INDIRECT_LOAD_DEC = 6'h0C;
  localparam logic [5:0] OP_DISPLACED_LOAD = 6'h0D;
  localparam logic [5:0] OP_DIRECT_LOAD = 6'h0E;
  localparam logic [5:0] OP_INDIRECT_WRITE = 6'h0F;
  localparam logic [5:0] OP_INDIRECT_WRITE_INC = 6'h10;
  localparam logic [5:0] OP_INDIRECT_WRITE_DEC = 6'h11;
  localparam logic [5:0] OP_DISPLACED_WRITE = 6'h12;
  localparam logic [5:0] OP_DIRECT_WRITE = 6'h13;
  localparam logic [5:0] OP_CODE_MEMORY_READ_R0 = 6'h14;
  localparam logic [5:0] OP_CODE_MEMORY_READ = 6'h15;
  localparam logic [5:0] OP_CODE_MEMORY_READ_INC = 6'h16;
  localparam logic [5:0] OP_PORT_IN = 6'h17;
  localparam logic [5:0] OP_PORT_OUT = 6'h18;
  localparam logic [5:0] OP_PUSH = 6'h19;
  localparam logic [5:0] OP_POP = 6'h1A;
  localparam logic [5:0] OP_SLEEP = 6'h1B;
  localparam logic [5:0] OP_WATCHDOG_KICK = 6'h1C;
  localparam logic [5:0] OP_BREAK = 6'h1D;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} btx_state_t;

endpackage

// *** core/btx_shift_unit.sv ***
// one-bit right shift with flag results for the executor
// purely combinational, used in the executor's step 0, the cycle after issue
`timescale 1ns/10ps
module btx_shift_unit (
  input wire logic arith_i,
  input wire logic [7:0] operand_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic carry_o,
  output logic zero_o,
  output logic neg_o,
  output logic ovf_o
);
  logic top;

  always_comb begin
    // arithmetic form keeps the sign, rotate feeds the old carry in
    top = arith_i ? operand_i[7] : carry_i;
    result_o = {top, operand_i[7:1]};
    carry_o = operand_i[0];
    zero_o = ({top, operand_i[7:1]} == 8'h00);
    neg_o = top;
    ovf_o = top ^ operand_i[0];
  end
endmodule

// *** core/btx_exec.sv ***
// executor for shift, flag, bit-transfer, load/store, stack and control ops
// assumes async-read data memory, two-cycle code memory, same clock for all
`timescale 1ns/10ps

module btx_exec #(
  parameter logic [15:0] SP_INIT = btx_pkg::SP_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [btx_pkg::BTX_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [btx_pkg::BTX_DAT_W-1:0] wb_dat_i,
  output logic [btx_pkg::BTX_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [btx_pkg::BTX_MEM_AW-1:0] dmem_addr_o,
  output logic [7:0] dmem_wdata_o,
  output logic dmem_we_o,
  output logic dmem_re_o,
  input wire logic [7:0] dmem_rdata_i,
  output logic [btx_pkg::BTX_MEM_AW-1:0] pmem_addr_o,
  output logic pmem_re_o,
  input wire logic [7:0] pmem_rdata_i,
  output logic [btx_pkg::BTX_IO_AW-1:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_we_o,
  input wire logic [7:0] io_rdata_i,
  output logic sleep_o,
  output logic wdt_kick_o,
  output logic break_o
);
  import btx_pkg::*;

  logic [7:0] rf [0:31];
  logic [31:0] cmd_reg;
  logic [15:0] imm_reg;
  logic [7:0] flags_reg;
  logic [15:0] sp_reg;
  logic [4:0] rf_idx_reg;
  logic err_reg;
  btx_state_t state_reg;
  logic [1:0] step_reg;
  logic [1:0] last_reg;

  logic bus_req;
  logic bus_wr;
  logic [31:0] cmd_new;
  logic [31:0] rd_word;
  logic accept;
  logic new_legal;
  logic busy;
  logic step0;
  logic [5:0] op;
  logic [1:0] psel;
  logic [4:0] rd_idx;
  logic [4:0] rr_idx;
  logic [2:0] bit_idx;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] eff_addr;

  logic aw_en;
  logic [4:0] aw_idx;
  logic [7:0] aw_dat;
  logic pw_en;
  logic [3:0] pw_pair;
  logic [15:0] pw_dat;
  logic [7:0] flags_next;
  logic [7:0] sh_res;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic [31:0] sp_merge;
  logic [31:0] imm_merge;

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [1:0] op_cycles(input logic [5:0] o);
    case (o)
      OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
      OP_DISPLACED_LOAD, OP_DIRECT_LOAD, OP_INDIRECT_WRITE,
      OP_INDIRECT_WRITE_INC, OP_INDIRECT_WRITE_DEC, OP_DISPLACED_WRITE,
      OP_DIRECT_WRITE, OP_PUSH, OP_POP: op_cycles = CYC_TWO;
      OP_CODE_MEMORY_READ_R0, OP_CODE_MEMORY_READ,
      OP_CODE_MEMORY_READ_INC: op_cycles = CYC_THREE;
      default: op_cycles = CYC_ONE;
    endcase
  endfunction

  function automatic logic [4:0] ptr_base(input logic [1:0] s);
    case (s)
      PTR_Y: ptr_base = PTR_Y_LO;
      PTR_Z: ptr_base = PTR_Z_LO;
      default: ptr_base = PTR_X_LO;
    endcase
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign busy = (state_reg == ST_EXEC);
  assign step0 = busy & (step_reg == 2'h0);
  assign cmd_new = wb_merge(cmd_reg, wb_dat_i, wb_sel_i);
  assign sp_merge = wb_merge({16'h0000, sp_reg}, wb_dat_i, wb_sel_i);
  assign imm_merge = wb_merge({16'h0000, imm_reg}, wb_dat_i, wb_sel_i);
  assign accept = bus_wr & (wb_adr_i == OFS_CMD) & ~busy;

  // displacement needs Y or Z; undefined codes are refused too
  always_comb begin
    new_legal = (cmd_new[CMD_OP_LSB +: 6] <= OP_BREAK);
    if ((cmd_new[CMD_OP_LSB +: 6] == OP_DISPLACED_LOAD ||
         cmd_new[CMD_OP_LSB +: 6] == OP_DISPLACED_WRITE) &&
        (cmd_new[CMD_PTR_LSB +: 2] != PTR_Y) &&
        (cmd_new[CMD_PTR_LSB +: 2] != PTR_Z)) begin
      new_legal = 1'b0;
    end
  end

  assign op = cmd_reg[CMD_OP_LSB +: 6];
  assign psel = cmd_reg[CMD_PTR_LSB +: 2];
  assign rd_idx = cmd_reg[CMD_RD_LSB +: 5];
  assign rr_idx = cmd_reg[CMD_RR_LSB +: 5];
  assign bit_idx = cmd_reg[CMD_BIT_LSB +: 3];
  // code reads always go through Z
  assign ptr_lo = (op >= OP_CODE_MEMORY_READ_R0 &&
                   op <= OP_CODE_MEMORY_READ_INC) ? PTR_Z_LO : ptr_base(psel);
  assign ptr_val = {rf[ptr_lo + 5'h01], rf[ptr_lo]};

  always_comb begin
    case (op)
      OP_INDIRECT_LOAD_DEC, OP_INDIRECT_WRITE_DEC:
        eff_addr = ptr_val - 16'h0001;
      OP_DISPLACED_LOAD, OP_DISPLACED_WRITE:
        eff_addr = ptr_val + {10'h000, imm_reg[5:0]};
      OP_DIRECT_LOAD, OP_DIRECT_WRITE:
        eff_addr = imm_reg;
      default: eff_addr = ptr_val;
    endcase
  end

  btx_shift_unit u_shift (
    .arith_i(op == OP_ARITH_SHIFT_RIGHT),
    .operand_i(rf[rd_idx]),
    .carry_i(flags_reg[FLG_C]),
    .result_o(sh_res),
    .carry_o(sh_c),
    .zero_o(sh_z),
    .neg_o(sh_n),
    .ovf_o(sh_v)
  );

  // register and flag writes of the running command
  always_comb begin
    aw_en = 1'b0;
    aw_idx = rd_idx;
    aw_dat = 8'h00;
    pw_en = 1'b0;
    pw_pair = ptr_lo[4:1];
    pw_dat = 16'h0000;
    flags_next = flags_reg;
    if (step0) begin
      case (op)
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
          aw_en = 1'b1;
          aw_dat = sh_res;
          flags_next[FLG_C] = sh_c;
          flags_next[FLG_Z] = sh_z;
          flags_next[FLG_N] = sh_n;
          flags_next[FLG_V] = sh_v;
        end
        OP_STATUS_BIT_SET: flags_next[bit_idx] = 1'b1;
        OP_STATUS_BIT_CLEAR: flags_next[bit_idx] = 1'b0;
        OP_BIT_TO_TRANSFER_FLAG:
          flags_next[FLG_T] = rf[rr_idx][bit_idx];
        OP_TRANSFER_FLAG_TO_BIT: begin
          aw_en = 1'b1;
          aw_dat = rf[rd_idx];
          aw_dat[bit_idx] = flags_reg[FLG_T];
        end
        OP_REG_COPY: begin
          aw_en = 1'b1;
          aw_dat = rf[rr_idx];
        end
        OP_REG_PAIR_COPY: begin
          pw_en = 1'b1;
          pw_pair = rd_idx[4:1];
          pw_dat = {rf[{rr_idx[4:1], 1'b1}], rf[{rr_idx[4:1], 1'b0}]};
        end
        OP_IMMEDIATE_LOAD: begin
          aw_en = 1'b1;
          aw_dat = imm_reg[7:0];
        end
        OP_PORT_IN: begin
          aw_en = 1'b1;
          aw_dat = io_rdata_i;
        end
        // memory already saw the old pointer, so stepping now is safe
        OP_INDIRECT_LOAD_INC, OP_INDIRECT_WRITE_INC,
        OP_CODE_MEMORY_READ_INC: begin
          pw_en = 1'b1;
          pw_dat = ptr_val + 16'h0001;
        end
        OP_INDIRECT_LOAD_DEC, OP_INDIRECT_WRITE_DEC: begin
          pw_en = 1'b1;
          pw_dat = eff_addr;
        end
        default: ;
      endcase
    end else if (busy && step_reg == last_reg) begin
      case (op)
        OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
        OP_DISPLACED_LOAD, OP_DIRECT_LOAD, OP_POP: begin
          aw_en = 1'b1;
          aw_dat = dmem_rdata_i;
        end
        OP_CODE_MEMORY_READ_R0: begin
          aw_en = 1'b1;
          aw_idx = REG_R0;
          aw_dat = pmem_rdata_i;
        end
        OP_CODE_MEMORY_READ, OP_CODE_MEMORY_READ_INC: begin
          aw_en = 1'b1;
          aw_dat = pmem_rdata_i;
        end
        default: ;
      endcase
    end
  end

  // register file; the running command beats a software write
  for (genvar i = 0; i < 32; i++) begin : g_rf
    localparam logic [4:0] IDX = 5'(i);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rf[i] <= 8'h00;
      end else if (pw_en && pw_pair == IDX[4:1]) begin
        rf[i] <= IDX[0] ? pw_dat[15:8] : pw_dat[7:0];
      end else if (aw_en && aw_idx == IDX) begin
        rf[i] <= aw_dat;
      end else if (bus_wr && wb_adr_i == OFS_RF_DAT && wb_sel_i[0] &&
                   rf_idx_reg == IDX) begin
        rf[i] <= wb_dat_i[7:0];
      end
    end
  end

  // hardware flag updates win over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= FLAGS_RESET;
    end else if (step0) begin
      flags_reg <= flags_next;
    end else if (bus_wr && wb_adr_i == OFS_STAT && wb_sel_i[0]) begin
      flags_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_reg <= SP_INIT;
    end else if (step0 && op == OP_PUSH) begin
      sp_reg <= sp_reg - 16'h0001;
    end else if (step0 && op == OP_POP) begin
      sp_reg <= sp_reg + 16'h0001;
    end else if (bus_wr && wb_adr_i == OFS_SP) begin
      sp_reg <= sp_merge[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imm_reg <= 16'h0000;
      rf_idx_reg <= 5'h00;
    end else begin
      if (bus_wr && wb_adr_i == OFS_IMM && !busy) begin
        imm_reg <= imm_merge[15:0];
      end
      if (bus_wr && wb_adr_i == OFS_RF_IDX && wb_sel_i[0]) begin
        rf_idx_reg <= wb_dat_i[4:0];
      end
    end
  end

  // issue sequencer; commands written while busy are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 32'h0000_0000;
      step_reg <= 2'h0;
      last_reg <= 2'h0;
      err_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            cmd_reg <= cmd_new;
            err_reg <= ~new_legal;
            step_reg <= 2'h0;
            last_reg <= op_cycles(cmd_new[CMD_OP_LSB +: 6]) - 2'h1;
            if (new_legal) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (step_reg == last_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            step_reg <= step_reg + 2'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // memory, port and control strobes, all one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_addr_o <= 16'h0000;
      dmem_wdata_o <= 8'h00;
      dmem_we_o <= 1'b0;
      dmem_re_o <= 1'b0;
      pmem_addr_o <= 16'h0000;
      io_addr_o <= 6'h00;
      io_wdata_o <= 8'h00;
      io_we_o <= 1'b0;
      sleep_o <= 1'b0;
      wdt_kick_o <= 1'b0;
      break_o <= 1'b0;
    end else begin
      dmem_we_o <= 1'b0;
      dmem_re_o <= 1'b0;
      io_we_o <= 1'b0;
      sleep_o <= step0 && op == OP_SLEEP;
      wdt_kick_o <= step0 && op == OP_WATCHDOG_KICK;
      break_o <= step0 && op == OP_BREAK;
      // port address is set at issue so a port read completes in step 0
      if (accept) begin
        io_addr_o <= imm_reg[5:0];
      end
      if (step0) begin
        case (op)
          OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
          OP_DISPLACED_LOAD, OP_DIRECT_LOAD: begin
            dmem_addr_o <= eff_addr;
            dmem_re_o <= 1'b1;
          end
          OP_INDIRECT_WRITE, OP_INDIRECT_WRITE_INC, OP_INDIRECT_WRITE_DEC,
          OP_DISPLACED_WRITE, OP_DIRECT_WRITE: begin
            dmem_addr_o <= eff_addr;
            dmem_wdata_o <= rf[rr_idx];
            dmem_we_o <= 1'b1;
          end
          OP_PUSH: begin
            dmem_addr_o <= sp_reg;
            dmem_wdata_o <= rf[rr_idx];
            dmem_we_o <= 1'b1;
          end
          OP_POP: begin
            dmem_addr_o <= sp_reg + 16'h0001;
            dmem_re_o <= 1'b1;
          end
          OP_CODE_MEMORY_READ_R0, OP_CODE_MEMORY_READ,
          OP_CODE_MEMORY_READ_INC: pmem_addr_o <= ptr_val;
          OP_PORT_OUT: begin
            io_wdata_o <= rf[rr_idx];
            io_we_o <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // code memory needs two cycles of stable address before data is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmem_re_o <= 1'b0;
    end else begin
      pmem_re_o <= busy && step_reg != CYC_TWO &&
                   op >= OP_CODE_MEMORY_READ_R0 &&
                   op <= OP_CODE_MEMORY_READ_INC;
    end
  end

  always_comb begin
    case (wb_adr_i)
      OFS_CMD: rd_word = cmd_reg;
      OFS_IMM: rd_word = {16'h0000, imm_reg};
      OFS_STAT: rd_word = {22'h000000, err_reg, busy, flags_reg};
      OFS_RF_IDX: rd_word = {27'h0000000, rf_idx_reg};
      OFS_RF_DAT: rd_word = {24'h000000, rf[rf_idx_reg]};
      OFS_SP: rd_word = {16'h0000, sp_reg};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
    end
  end
endmodule

// *** bench/btx_mem_model.sv ***
// data, code and port memory standing at the executor's far side
// assumes the executor's strobes: async data read, code data held while re
`timescale 1ns/10ps
module btx_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] dmem_addr_i,
  input wire logic [7:0] dmem_wdata_i,
  input wire logic dmem_we_i,
  input wire logic dmem_re_i,
  output logic [7:0] dmem_rdata_o,
  input wire logic [15:0] pmem_addr_i,
  input wire logic pmem_re_i,
  output logic [7:0] pmem_rdata_o,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_we_i,
  output logic [7:0] io_rdata_o
);
  logic [7:0] mem [256];
  logic [13:0] io_last;
  logic [7:0] dv;
  logic [7:0] pv;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end
  always @(posedge clk_i) begin
    if (dmem_we_i) begin
      mem[dmem_addr_i[7:0]] <= dmem_wdata_i;
    end
    if (io_we_i) begin
      io_last <= {io_addr_i, io_wdata_i};
    end
  end
  assign dv = mem[dmem_addr_i[7:0]];
  assign pv = pmem_addr_i[15:8] ^ pmem_addr_i[7:0] ^ 8'h5A;
  // off strobe the data is inverted, so a late sample cannot pass
  assign dmem_rdata_o = dmem_re_i ? dv : ~dv;
  assign pmem_rdata_o = pmem_re_i ? pv : ~pv;
  assign io_rdata_o = {2'h2, io_addr_i};
endmodule

// *** bench/btx_exec_sva.sv ***
// checker for the executor's bus answer and memory strobe timing
// assumes one clock and that only idle, legal command writes start work
`timescale 1ns/10ps
module btx_exec_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [btx_pkg::BTX_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [btx_pkg::BTX_DAT_W-1:0] wb_dat_i,
  input wire logic [btx_pkg::BTX_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dmem_we_o,
  input wire logic dmem_re_o,
  input wire logic pmem_re_o,
  input wire logic io_we_o,
  input wire logic sleep_o,
  input wire logic wdt_kick_o,
  input wire logic break_o
);
  import btx_pkg::*;
  logic [1:0] cnt;
  logic [5:0] op;
  logic acc, ld, st, cr;
  assign op = wb_dat_i[5:0];
  assign ld = op inside {[OP_INDIRECT_LOAD:OP_DIRECT_LOAD], OP_POP};
  assign st = op inside {[OP_INDIRECT_WRITE:OP_DIRECT_WRITE], OP_PUSH};
  assign cr = op inside {[OP_CODE_MEMORY_READ_R0:OP_CODE_MEMORY_READ_INC]};
  // busy and illegal writes start nothing, so they must not count here
  assign acc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == OFS_CMD && cnt == 2'h0 && op <= OP_BREAK
    && !(op inside {OP_DISPLACED_LOAD, OP_DISPLACED_WRITE}
    && !(wb_dat_i[7:6] inside {PTR_Y, PTR_Z}));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 2'h0;
    end else if (acc) begin
      cnt <= cr ? CYC_THREE : (ld || st) ? CYC_TWO : CYC_ONE;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_late_pulse(sig);
    ##1 !sig ##1 sig ##1 !sig;
  endsequence
  sequence s_code_fetch;
    ##1 !pmem_re_o ##1 pmem_re_o [*2] ##1 !pmem_re_o;
  endsequence
  a_ack_next_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after the request");
  a_rdata_gated: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data driven without ack");
  a_load_strobe: assert property (
    acc && ld |-> s_late_pulse(dmem_re_o))
    else $error("load read strobe not in second cycle");
  a_store_strobe: assert property (
    acc && st |-> s_late_pulse(dmem_we_o))
    else $error("store write strobe not in second cycle");
  a_code_fetch: assert property (acc && cr |-> s_code_fetch)
    else $error("code read strobe not two cycles after issue");
  a_port_write: assert property (
    acc && op == OP_PORT_OUT |-> s_late_pulse(io_we_o))
    else $error("port write strobe misplaced");
  a_sleep_pulse: assert property (
    acc && op == OP_SLEEP |-> s_late_pulse(sleep_o))
    else $error("sleep pulse misplaced");
  a_kick_pulse: assert property (
    acc && op == OP_WATCHDOG_KICK |-> s_late_pulse(wdt_kick_o))
    else $error("watchdog kick pulse misplaced");
  a_break_pulse: assert property (
    acc && op == OP_BREAK |-> s_late_pulse(break_o))
    else $error("break pulse misplaced");
endmodule

bind btx_exec btx_exec_sva i_btx_exec_sva (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .dmem_we_o, .dmem_re_o, .pmem_re_o, .io_we_o, .sleep_o,
  .wdt_kick_o, .break_o);

// *** bench/test_btx_exec.sv ***
// random command stream through the executor, checked against a model
// assumes btx_mem_model at the memory side and the bound checker
`timescale 1ns/10ps
module test_btx_exec;
  import btx_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, wb_ack_o, dmem_we_o, dmem_re_o, pmem_re_o;
  logic io_we_o, sleep_o, wdt_kick_o, break_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, v;
  logic [15:0] dmem_addr_o, pmem_addr_o;
  logic [7:0] dmem_wdata_o, dmem_rdata_i, pmem_rdata_i, io_wdata_o;
  logic [7:0] io_rdata_i;
  logic [5:0] io_addr_o, op;
  int failures = 0, num_checks = 0, rf[32], dm[256], fl, sp, err;
  int p, d, r, b, imm;
  btx_exec i_btx_exec (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dmem_addr_o,
    .dmem_wdata_o, .dmem_we_o, .dmem_re_o, .dmem_rdata_i, .pmem_addr_o,
    .pmem_re_o, .pmem_rdata_i, .io_addr_o, .io_wdata_o, .io_we_o,
    .io_rdata_i, .sleep_o, .wdt_kick_o, .break_o);
  btx_mem_model i_btx_mem_model (.clk_i, .dmem_addr_i(dmem_addr_o),
    .dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o),
    .dmem_re_i(dmem_re_o), .dmem_rdata_o(dmem_rdata_i),
    .pmem_addr_i(pmem_addr_o), .pmem_re_i(pmem_re_o),
    .pmem_rdata_o(pmem_rdata_i), .io_addr_i(io_addr_o),
    .io_wdata_i(io_wdata_o), .io_we_i(io_we_o), .io_rdata_o(io_rdata_i));
  always #25 clk_i = ~clk_i;
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
           output logic [31:0] rd);
    int n;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task rreg(input int i);
    bus(OFS_RF_IDX, 1'h1, 32'(i), v);
    bus(OFS_RF_DAT, 1'h0, 32'h0, v);
  endtask
  function automatic int pr(int n);
    return rf[26 + 2 * n] | rf[27 + 2 * n] << 8;
  endfunction
  function automatic void setp(int n, int x);
    rf[26 + 2 * n] = x & 255;
    rf[27 + 2 * n] = x >> 8 & 255;
  endfunction
  task exe;
    int n, a;
    bus(OFS_IMM, 1'h1, 32'(imm), q);
    bus(OFS_CMD, 1'h1,
        {5'h00, 3'(b), 3'h0, 5'(r), 3'h0, 5'(d), 2'(p), op}, q);
    n = 0;
    do begin
      bus(OFS_STAT, 1'h0, 32'h0, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'h0 && n < 10);
    if (n >= 10) begin
      failures++;
      end_of_test;
    end
    err = op > OP_BREAK
      || (p == 0 && op inside {OP_DISPLACED_LOAD, OP_DISPLACED_WRITE});
    if (err == 0) begin
      a = pr(op inside {[OP_CODE_MEMORY_READ_R0:OP_CODE_MEMORY_READ_INC]}
        ? 2 : p);
      if (op inside {OP_INDIRECT_LOAD_DEC, OP_INDIRECT_WRITE_DEC}) begin
        a = a - 1;
        setp(p, a);
      end
      if (op inside {OP_INDIRECT_LOAD_INC, OP_INDIRECT_WRITE_INC}) begin
        setp(p, a + 1);
      end
      if (op == OP_CODE_MEMORY_READ_INC) setp(2, a + 1);
      if (op inside {OP_DISPLACED_LOAD, OP_DISPLACED_WRITE}) a += imm & 63;
      if (op inside {OP_DIRECT_LOAD, OP_DIRECT_WRITE}) a = imm;
      case (op) inside
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
          n = rf[d] >> 1
            | ((op == OP_ARITH_SHIFT_RIGHT ? rf[d] >> 7 : fl) & 1) << 7;
          fl = fl & 240 | rf[d] & 1 | (n == 0) << 1 | (n >> 7) << 2
            | ((n >> 7) ^ rf[d] & 1) << 3;
          rf[d] = n;
        end
        OP_STATUS_BIT_SET: fl = fl | 1 << b;
        OP_STATUS_BIT_CLEAR: fl = fl & ~(1 << b);
        OP_BIT_TO_TRANSFER_FLAG: fl = fl & 191 | (rf[r] >> b & 1) << 6;
        OP_TRANSFER_FLAG_TO_BIT:
          rf[d] = rf[d] & ~(1 << b) | (fl >> 6 & 1) << b;
        OP_REG_COPY: rf[d] = rf[r];
        OP_REG_PAIR_COPY: begin
          rf[d & 30] = rf[r & 30];
          rf[d | 1] = rf[r | 1];
        end
        OP_IMMEDIATE_LOAD: rf[d] = imm & 255;
        [OP_INDIRECT_LOAD:OP_DIRECT_LOAD]: rf[d] = dm[a & 255];
        [OP_INDIRECT_WRITE:OP_DIRECT_WRITE]: dm[a & 255] = rf[r];
        OP_CODE_MEMORY_READ_R0: rf[0] = (a >> 8 ^ a ^ 90) & 255;
        OP_CODE_MEMORY_READ, OP_CODE_MEMORY_READ_INC:
          rf[d] = (a >> 8 ^ a ^ 90) & 255;
        OP_PORT_IN: rf[d] = imm & 63 | 128;
        OP_PUSH: begin
          dm[sp & 255] = rf[r];
          sp = (sp - 1) & 65535;
        end
        OP_POP: begin
          sp = (sp + 1) & 65535;
          rf[d] = dm[sp & 255];
        end
        default: ;
      endcase
    end
    chk(q, 32'(fl | err << 9));
    rreg(d);
    chk(v, 32'(rf[d]));
    bus(OFS_SP, 1'h0, 32'h0, v);
    chk(v, 32'(sp));
  endtask
  initial begin
    void'($urandom(32'h1b3f));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    bus(OFS_STAT, 1'h0, 32'h0, q);
    chk(q, 32'h0);
    bus(OFS_SP, 1'h0, 32'h0, q);
    chk(q, 32'h00FF);
    // low lane only: the high byte of the stack pointer must stay
    wb_sel_i <= 4'h1;
    bus(OFS_SP, 1'h1, 32'h0000_AB12, q);
    wb_sel_i <= 4'hF;
    bus(OFS_SP, 1'h0, 32'h0, q);
    chk(q, 32'h0012);
    bus(8'h40, 1'h0, 32'h0, q);
    chk(q, 32'h0);
    sp = 18;
    fl = $urandom & 255;
    bus(OFS_STAT, 1'h1, 32'(fl), q);
    for (int i = 0; i < 32; i++) begin
      rf[i] = $urandom & 255;
      bus(OFS_RF_IDX, 1'h1, 32'(i), q);
      bus(OFS_RF_DAT, 1'h1, 32'(rf[i]), q);
    end
    for (int i = 0; i < 256; i++) dm[i] = i ^ 60;
    // codes 0 to 31 once, illegal 30 and 31 included, then a random mix of codes 0 to 31
    for (int k = 0; k < 200; k++) begin
      op = k < 32 ? 6'(k) : 6'($urandom % 32);
      p = $urandom % 3;
      d = $urandom % 26;
      r = $urandom % 26;
      b = $urandom % 8;
      imm = $urandom & 65535;
      exe();
      v = 32'(i_btx_mem_model.io_last);
      if (op == OP_PORT_OUT) chk(v, 32'((imm & 63) << 8 | rf[r]));
    end
    for (int i = 0; i < 32; i++) begin
      rreg(i);
      chk(v, 32'(rf[i]));
    end
    for (int i = 0; i < 256; i++) begin
      v = 32'(i_btx_mem_model.mem[i]);
      chk(v, 32'(dm[i]));
    end
    end_of_test;
  end
endmodule
